/* cbc_cell_load.sv */
// cbc_cell_load: behavioural discharge load on each balanced cell
`timescale 1ns/1ns
`default_nettype none
module cbc_cell_load (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // gate drive and meter restart
   input  wire logic [13:0] gate,
   input  wire logic        clr,
   // discharge meters, cycles of sinking
   output var  int          on_time [14]
);
   // fet sinks only on a solid high gate; an unknown gate never counts
   always @(posedge core_clk or negedge resetn) begin
      for (int k = 0; k < 14; k++) begin
         if (!resetn || clr) on_time[k] <= 0;
         else if (gate[k] === 1'b1) on_time[k] <= on_time[k] + 1;
      end
   end
endmodule
`default_nettype wire

/* cbc_core.sv */
// cbc_core: balancing fsm, timers, watchdog and cell drive
`timescale 1ns/1ns
`default_nettype none
module cbc_core #(
   parameter int          CELLS       = cbc_pkg::CELLS,
   parameter int          STEP_CYCLES = cbc_pkg::FINE_STEP_CYC,
   parameter logic [15:0] WDOG_STEPS  = cbc_pkg::WDOG_STEPS_DEF
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   // configuration
   input  wire logic [1:0]           bal_mode,
   input  wire logic                 timer_resolution_select,
   input  wire logic                 sleep_bal_conf,
   input  wire logic [CELLS-1:0]     cell_measure_enable,
   input  wire logic [2*CELLS-1:0]   cell_select_field,
   input  wire logic [7*CELLS-1:0]   cell_duration_threshold,
   input  wire logic [CELLS-1:0]     manual_drive,
   // command write
   input  wire logic                 cmd_write,
   input  wire logic                 bal_start,
   input  wire logic                 bal_stop,
   // system events
   input  wire logic                 conv_pause,
   input  wire logic                 go_to_sleep_cmd,
   input  wire logic                 comm_timeout,
   input  wire logic                 wake_to_normal,
   input  wire logic                 error_clear,
   // status and drive
   output logic [CELLS-1:0]          cell_drive_output,
   output logic                      bal_active,
   output logic                      bal_done,
   output logic                      silent_balancing,
   output logic                      watchdog_timeout_error,
   output logic                      fault_out
);
   initial begin
      if (CELLS < 1 || CELLS > cbc_pkg::CELLS)
         $error("cbc_core: CELLS out of range");
      if (WDOG_STEPS == 16'h0000)
         $error("cbc_core: zero watchdog timeout");
   end

   // threshold of one cell
   function automatic logic [6:0] cell_thr(
      input logic [7*CELLS-1:0] v, input int i);
      cell_thr = v[7*i +: 7];
   endfunction

   // cell picked by its select field
   function automatic logic cell_sel(
      input logic [2*CELLS-1:0] v, input int i);
      cell_sel = (v[2*i +: 2] == cbc_pkg::SEL_BALANCE);
   endfunction

   cbc_pkg::cbc_state_e st_r, st_nxt;     // balancing fsm
   logic [CELLS-1:0]    act_r, act_nxt;   // cells still balancing
   logic [6:0]          gt_r, gt_nxt;     // global_duration_timer
   logic [15:0]         wd_r, wd_nxt;     // duration_watchdog_timer
   logic                err_r, err_nxt;   // watchdog_timeout_error
   logic                sil_r, sil_nxt;   // silent balancing
   logic [CELLS-1:0]    drv_r, drv_nxt;   // registered drive
   logic                restart;          // prescaler restart
   logic                step;             // timer step enable
   logic                is_manual;        // manual mode now
   logic                is_timed;         // timed mode now
   logic                cmd_go;           // start code written
   logic                cmd_halt;         // stop code written
   logic                sleep_ev;         // sleep request or timeout
   logic [CELLS-1:0]    zero_mask;        // cells with zero threshold
   logic [CELLS-1:0]    pick;             // cells chosen at start

   // mode decode is live, so a switch applies at once
   assign is_manual = (bal_mode == cbc_pkg::MODE_MANUAL);
   assign is_timed  = (bal_mode == cbc_pkg::MODE_TIMED);
   // only the two exact codes act; others are ignored
   assign cmd_go    = cmd_write && bal_start && !bal_stop;
   assign cmd_halt  = cmd_write && !bal_start && bal_stop;
   assign sleep_ev  = go_to_sleep_cmd || comm_timeout;

   // per-cell decode of selection and zero thresholds
   always_comb begin
      pick      = '0;
      zero_mask = '0;
      for (int i = 0; i < CELLS; i++) begin
         // enabled and selected cells only
         pick[i]      = cell_measure_enable[i] &&
                        cell_sel(cell_select_field, i);
         zero_mask[i] = (cell_thr(cell_duration_threshold, i) ==
                         cbc_pkg::THR_ZERO);
      end
   end

   // timers are frozen while a conversion borrows the cells
   cbc_tick #(
      .STEP_CYCLES (STEP_CYCLES),
      .RATIO       (cbc_pkg::COARSE_RATIO)
   ) u_tick (
      .core_clk (core_clk),
      .resetn   (resetn),
      .run      ((st_r == cbc_pkg::CBC_RUN) && !conv_pause),
      .restart  (restart),
      .fine     (timer_resolution_select),
      .step     (step)
   );

   // fsm, timers and cell mask next state; later blocks take priority
   always_comb begin
      st_nxt  = st_r;
      act_nxt = act_r;
      gt_nxt  = gt_r;
      wd_nxt  = wd_r;
      err_nxt = err_r;
      sil_nxt = sil_r;
      restart = 1'b0;
      // clear first so a same-cycle expiry still sets the latch
      if (error_clear) begin
         err_nxt = 1'b0;
      end
      if (st_r == cbc_pkg::CBC_RUN) begin
         // both timers count the same step, saturating
         if (step) begin
            if (gt_r != cbc_pkg::THR_MAX)
               gt_nxt = gt_r + 7'h01;
            if (wd_r != 16'hffff)
               wd_nxt = wd_r + 16'h0001;
         end
         if (is_timed) begin
            // either timer reaching the threshold ends the cell
            for (int i = 0; i < CELLS; i++) begin
               if (gt_r >= cell_thr(cell_duration_threshold, i) ||
                   wd_r[6:0] >= cell_thr(cell_duration_threshold, i) ||
                   wd_r[15:7] != 9'h000) begin
                  act_nxt[i] = 1'b0;
               end
            end
            if (act_nxt == '0) begin
               st_nxt = cbc_pkg::CBC_DONE;
               gt_nxt = 7'h00;
            end
         end else if (is_manual && wd_r >= WDOG_STEPS) begin
            // watchdog expiry stops and latches the error
            st_nxt  = cbc_pkg::CBC_IDLE;
            act_nxt = '0;
            err_nxt = 1'b1;
         end
         if (sleep_ev) begin
            if (is_timed && sleep_bal_conf) begin
               sil_nxt = 1'b1;
            end else begin
               // manual never goes silent
               st_nxt  = cbc_pkg::CBC_IDLE;
               act_nxt = '0;
            end
         end
         // leaving low power always ends balancing
         if (wake_to_normal) begin
            st_nxt  = cbc_pkg::CBC_IDLE;
            act_nxt = '0;
         end
      end
      if (cmd_halt) begin
         // only way back to idle after done
         st_nxt  = cbc_pkg::CBC_IDLE;
         act_nxt = '0;
         gt_nxt  = 7'h00;
         wd_nxt  = 16'h0000;
      end else if (cmd_go && (is_manual || is_timed)) begin
         if (st_r == cbc_pkg::CBC_IDLE) begin
            // mask frozen here; later edits ignored
            st_nxt  = cbc_pkg::CBC_RUN;
            act_nxt = pick;
            gt_nxt  = 7'h00;
            wd_nxt  = 16'h0000;
            restart = 1'b1;
         end else if (st_r == cbc_pkg::CBC_RUN && is_manual) begin
            wd_nxt  = 16'h0000;
            restart = 1'b1;
         end
      end
      if (st_nxt != cbc_pkg::CBC_RUN) begin
         sil_nxt = 1'b0;
      end
      // drive: paused during conversion, host gated in manual
      if (conv_pause) begin
         drv_nxt = '0;
      end else if (is_manual) begin
         drv_nxt = act_nxt & manual_drive;
      end else begin
         drv_nxt = act_nxt;
      end
   end

   // state registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r  <= cbc_pkg::CBC_IDLE;
         act_r <= '0;
         gt_r  <= 7'h00;
         wd_r  <= 16'h0000;
         err_r <= 1'b0;
         sil_r <= 1'b0;
         drv_r <= '0;
      end else begin
         st_r  <= st_nxt;
         act_r <= act_nxt;
         gt_r  <= gt_nxt;
         wd_r  <= wd_nxt;
         err_r <= err_nxt;
         sil_r <= sil_nxt;
         drv_r <= drv_nxt;
      end
   end

   // status flags decode one state, so both never show
   assign bal_active             = (st_r == cbc_pkg::CBC_RUN);
   assign bal_done               = (st_r == cbc_pkg::CBC_DONE);
   assign silent_balancing       = sil_r;
   assign watchdog_timeout_error = err_r;
   assign fault_out              = err_r;
   assign cell_drive_output      = drv_r;

   // checks on the fsm and drive
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   flags_exclusive_a: assert property (
      !(bal_active && bal_done))
      else $error("active and done both set");

   start_runs_a: assert property (
      cmd_go && !cmd_halt && (is_manual || is_timed) &&
      st_r == cbc_pkg::CBC_IDLE |=> bal_active && act_r == $past(pick))
      else $error("start did not begin balancing");

   stop_idles_a: assert property (
      cmd_halt |=> !bal_active && !bal_done && cell_drive_output == '0)
      else $error("stop did not return to idle");

   pause_keeps_a: assert property (
      conv_pause && !cmd_write && !sleep_ev && !wake_to_normal &&
      !is_timed && !(is_manual && wd_r >= WDOG_STEPS)
      |=> cell_drive_output == '0 && $stable(act_r))
      else $error("pause lost balancing state");

   zero_thr_a: assert property (
      bal_active && is_timed && (act_r & zero_mask) != '0 &&
      !cmd_write |=> (act_r & $past(zero_mask)) == '0)
      else $error("zero threshold cell still active");

   mask_frozen_a: assert property (
      bal_active ##1 bal_active |-> (act_r & ~$past(act_r)) == '0)
      else $error("cell added after start");

   wdog_expire_a: assert property (
      bal_active && is_manual && wd_r >= WDOG_STEPS && !cmd_write
      |=> watchdog_timeout_error && fault_out && !bal_active)
      else $error("watchdog expiry not handled");

   sleep_manual_a: assert property (
      bal_active && is_manual && sleep_ev && !cmd_go
      |=> !bal_active && !silent_balancing && cell_drive_output == '0)
      else $error("manual balancing survived sleep");

   sleep_silent_a: assert property (
      bal_active && is_timed && sleep_bal_conf && sleep_ev &&
      !wake_to_normal && !cmd_halt |=> silent_balancing || bal_done)
      else $error("silent balancing not entered");

   wake_stops_a: assert property (
      bal_active && wake_to_normal |=> !bal_active)
      else $error("wake did not stop balancing");

   done_reset_a: assert property (
      $rose(bal_done) |-> gt_r == 7'h00 && act_r == '0)
      else $error("done without timer reset");

   // timers may only be cleared, never stepped, while paused
   pause_freeze_a: assert property (
      conv_pause |=> ($stable(gt_r) || gt_r == 7'h00) &&
      ($stable(wd_r) || wd_r == 16'h0000))
      else $error("timer stepped during pause");

   err_hold_a: assert property (
      watchdog_timeout_error && !error_clear |=> watchdog_timeout_error)
      else $error("timeout error latch lost");

   done_holds_a: assert property (
      bal_done && !cmd_halt |=> bal_done)
      else $error("done left without stop");

   drive_in_mask_a: assert property (
      (cell_drive_output & ~act_r) == '0)
      else $error("drive outside balancing mask");

   silent_in_run_a: assert property (
      silent_balancing |-> bal_active)
      else $error("silent balancing while not running");

   run_seen_c:    cover property (cmd_go ##1 bal_active);
   done_seen_c:   cover property (bal_active ##1 bal_done);
   wdog_seen_c:   cover property ($rose(watchdog_timeout_error));
   silent_seen_c: cover property ($rose(silent_balancing));
   pause_seen_c:  cover property (bal_active && conv_pause);
endmodule
`default_nettype wire

/* cbc_pkg.sv */
// cbc_pkg: constants for the cell balance controller
// Behaviour
// - mode field 01 manual, 10 timed
// - start=1 stop=0 starts; reverse stops; else hold
// - conversion pause keeps state, then resumes
// - manual to timed switch applies at once
// - zero threshold ends that cell at once
// - active/done flags: idle, over, ongoing
// - only enabled cells; later changes ignored
// - manual: host drives each of 14 outputs
// - manual: sleep or timeout halts, no silent
// - manual start restarts watchdog; expiry faults
// - timed: both timers start; either ends cell
// - all cells done: timer reset, done set
// - resolution 0 coarse 8m32s, 1 fine 4s
// - per-cell 7-bit threshold times step
// - timed, sleep-balance 0: sleep stops balancing
// - timed, sleep-balance 1: silent balancing continues
// - wake to normal always stops balancing
package cbc_pkg;
   localparam int          CELLS        = 14;    // stacked cells
   localparam int          THR_W        = 7;     // threshold width
   localparam int          SEL_W        = 2;     // select field width
   localparam logic [1:0]  MODE_MANUAL  = 2'h1;  // mode code 01
   localparam logic [1:0]  MODE_TIMED   = 2'h2;  // mode code 10
   localparam logic [1:0]  SEL_BALANCE  = 2'h2;  // select code 10
   localparam logic [6:0]  THR_ZERO     = 7'h00; // zero duration
   localparam logic [6:0]  THR_MAX      = 7'h7f; // timer saturation
   localparam int          CLK_HZ       = 100_000_000;
   localparam int          FINE_STEP_S  = 4;     // fine step, seconds
   localparam int          COARSE_STEP_S = 512;  // 8 min 32 sec
   // fine step in clock cycles: 400 million, fits 31 bits
   localparam int          FINE_STEP_CYC = FINE_STEP_S * CLK_HZ;
   // fine steps per coarse step
   localparam int          COARSE_RATIO = COARSE_STEP_S / FINE_STEP_S;
   localparam logic [15:0] WDOG_STEPS_DEF = 16'h00ff; // plain default
   localparam int          WD_W         = 16;    // watchdog width
   // balancing fsm
   typedef enum logic [1:0] {CBC_IDLE, CBC_RUN, CBC_DONE} cbc_state_e;
endpackage

/* cbc_tick.sv */
// cbc_tick: step enable generator for the balancing timers
`timescale 1ns/1ns
`default_nettype none
module cbc_tick #(
   parameter int STEP_CYCLES = cbc_pkg::FINE_STEP_CYC,
   parameter int RATIO       = cbc_pkg::COARSE_RATIO
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // control
   input  wire logic run,       // counting allowed
   input  wire logic restart,   // clear both prescalers
   input  wire logic fine,      // 1 fine, 0 coarse
   // step out
   output logic      step       // one-cycle step pulse
);
   initial begin
      // the coarse prescaler is eight bits wide
      if (STEP_CYCLES < 1 || RATIO < 2 || RATIO > 256)
         $error("cbc_tick: bad step parameters");
   end

   logic [31:0] cyc_r, cyc_nxt;   // cycles within a fine step
   logic [7:0]  crs_r, crs_nxt;   // fine steps within a coarse step
   logic        fine_ev;          // a fine step has elapsed

   // prescaler next state; restart wins over counting
   always_comb begin
      cyc_nxt = cyc_r;
      crs_nxt = crs_r;
      fine_ev = 1'b0;
      step    = 1'b0;
      if (restart) begin
         cyc_nxt = 32'h0000_0000;
         crs_nxt = 8'h00;
      end else if (run) begin
         if (cyc_r == 32'(STEP_CYCLES - 1)) begin
            cyc_nxt = 32'h0000_0000;
            fine_ev = 1'b1;
         end else begin
            cyc_nxt = cyc_r + 32'h0000_0001;
         end
         // coarse step is a run of fine steps
         if (fine_ev) begin
            if (fine) begin
               step = 1'b1;
            end else if (crs_r == 8'(RATIO - 1)) begin
               crs_nxt = 8'h00;
               step    = 1'b1;
            end else begin
               crs_nxt = crs_r + 8'h01;
            end
         end
      end
   end

   // prescaler registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cyc_r <= 32'h0000_0000;
         crs_r <= 8'h00;
      end else begin
         cyc_r <= cyc_nxt;
         crs_r <= crs_nxt;
      end
   end
endmodule
`default_nettype wire

/* test_cell_balance_controller.sv */
// test_cell_balance_controller: self-checking bench for cbc_core
`timescale 1ns/1ns
`default_nettype none
module test_cell_balance_controller;
   localparam int STEP = 10;                       // shortened fine step
   localparam int CRS  = STEP * cbc_pkg::COARSE_RATIO; // coarse step
   logic        core_clk, resetn, res_sel, conf, cmd_write, start, stop;
   logic        pause, slp, tmo, wake, eclr, clr;   // events
   logic [1:0]  bal_mode;
   logic [13:0] en, md, drive, m;
   logic [27:0] sel;
   logic [97:0] thr;
   logic        act, done, silent, werr, fault;    // status seen
   int          on_time [14];
   int          n_mismatch, tests_run, seed, i, k, st;
   cbc_core #(.STEP_CYCLES(STEP), .WDOG_STEPS(16'h0003)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .bal_mode(bal_mode),
      .timer_resolution_select(res_sel), .sleep_bal_conf(conf),
      .cell_measure_enable(en), .cell_select_field(sel),
      .cell_duration_threshold(thr), .manual_drive(md),
      .cmd_write(cmd_write), .bal_start(start), .bal_stop(stop),
      .conv_pause(pause), .go_to_sleep_cmd(slp), .comm_timeout(tmo),
      .wake_to_normal(wake), .error_clear(eclr),
      .cell_drive_output(drive), .bal_active(act), .bal_done(done),
      .silent_balancing(silent), .watchdog_timeout_error(werr),
      .fault_out(fault));
   cbc_cell_load i_load (.core_clk(core_clk), .resetn(resetn),
      .gate(drive), .clr(clr), .on_time(on_time));
   // free-running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // expected mask: enabled and selected with code 10
   function automatic logic [13:0] exp_mask(logic [13:0] e, logic [27:0] s);
      for (int j = 0; j < 14; j++)
         exp_mask[j] = e[j] && s[2*j+:2] == cbc_pkg::SEL_BALANCE;
   endfunction
   task automatic chk_bit(string nm, logic e, logic g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_vec(string nm, logic [13:0] e, logic [13:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_num(string nm, int lo, int hi, int g);
      tests_run++;
      if (g < lo || g > hi) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // wait n falling edges; every stimulus change lands there
   task automatic cyc(int n);
      repeat (n) @(negedge core_clk);
   endtask
   // command write: qualifier high for one edge, then one idle edge,
   // so back-to-back calls never re-raise it in the same time step
   task automatic cmd(logic s, logic p);
      cmd_write = 1'b1;
      start = s;
      stop = p;
      cyc(1);
      cmd_write = 1'b0;
      cyc(1);
   endtask
   // one-cycle event pulse: 0 sleep, 1 timeout, 2 wake, 3 clear
   task automatic ev(int n);
      {eclr, wake, tmo, slp} = 4'h1 << n;
      cyc(1);
      {eclr, wake, tmo, slp} = 4'h0;
   endtask
   // bounded wait for the done flag
   task automatic wait_done(int lim);
      for (int j = 0; j < lim && done !== 1'b1; j++) cyc(1);
   endtask
   // timed run on random cells; fine or coarse step
   task automatic timed_run(logic fine);
      int lo;                                       // expected on-time
      st = fine ? STEP : CRS;
      en = 14'($random(seed)) | 14'h0001;
      sel = 28'($random(seed));
      sel[1:0] = cbc_pkg::SEL_BALANCE;              // cell 0 always picked
      for (k = 0; k < 14; k++)
         thr[7*k+:7] = fine ? 7'(($random(seed) & 7) + 1) : 7'h01;
      m = exp_mask(en, sel);
      bal_mode = cbc_pkg::MODE_TIMED;
      res_sel = fine;
      // meters restart one edge before the start command
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cmd(1'b1, 1'b0);
      chk_bit("active", 1'b1, act);
      chk_vec("drive", m, drive);
      // later edits of enable and select must not matter
      en = ~en;
      sel = 28'h000_0000;
      cyc(2);
      chk_vec("drive held", m, drive);
      wait_done(9 * st + 20);
      chk_bit("done", 1'b1, done);
      chk_bit("active off", 1'b0, act);
      chk_vec("drive off", 14'h0000, drive);
      // each cell sinks for its own code times the step, plus one edge
      for (k = 0; k < 14; k++) begin
         lo = int'(thr[7*k+:7]) * st;
         if (m[k])
            chk_num("on time", lo-1, lo+3, on_time[k]);
      end
      cmd(1'b1, 1'b0);                              // go refused in done
      chk_bit("go in done", 1'b1, done);
      cmd(1'b0, 1'b1);
      chk_bit("idle", 1'b0, done);
   endtask
   // watchdog: the run needs about 1700 cycles; allow 20000
   initial begin
      #200000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      seed = 56767;
      n_mismatch = 0;
      tests_run = 0;
      resetn = 1'b0;
      {res_sel, conf, cmd_write, start, stop, pause, clr} = 7'h00;
      {slp, tmo, wake, eclr} = 4'h0;
      bal_mode = 2'h0;
      en = 14'h0000;
      md = 14'h0000;
      sel = 28'h000_0000;
      thr = 98'h0;
      cyc(16);
      resetn = 1'b1;
      chk_bit("reset active", 1'b0, act);
      chk_bit("reset done", 1'b0, done);
      // inert mode codes refuse the start
      cmd(1'b1, 1'b0);
      chk_bit("mode 00 go", 1'b0, act);
      bal_mode = 2'h3;
      cmd(1'b1, 1'b0);
      chk_bit("mode 11 go", 1'b0, act);
      bal_mode = cbc_pkg::MODE_MANUAL;
      cmd(1'b1, 1'b1);
      chk_bit("both set", 1'b0, act);
      en = 14'h3fff;
      sel = {14{cbc_pkg::SEL_BALANCE}};
      md = 14'($random(seed));
      // start, then two inert codes back to back
      cmd(1'b1, 1'b0);
      cmd(1'b1, 1'b1);
      cmd(1'b0, 1'b0);
      chk_bit("manual run", 1'b1, act);
      chk_vec("manual drive", md, drive);
      md = ~md;
      cyc(2);
      chk_vec("manual follow", md, drive);
      pause = 1'b1;
      cyc(2);
      chk_vec("paused", 14'h0000, drive);
      pause = 1'b0;
      cyc(2);
      chk_vec("resumed", md, drive);
      // live switch to timed; fine step so five steps end it soon
      md = 14'h3fff;
      thr = {14{7'h05}};
      res_sel = 1'b1;
      bal_mode = cbc_pkg::MODE_TIMED;
      cyc(1);
      chk_bit("switch run", 1'b1, act);
      chk_vec("switch drive", 14'h3fff, drive);
      wait_done(80);
      chk_bit("switch done", 1'b1, done);
      chk_vec("switch off", 14'h0000, drive);
      cmd(1'b0, 1'b1);
      // manual watchdog of three fine steps, restarted once
      bal_mode = cbc_pkg::MODE_MANUAL;
      cmd(1'b1, 1'b0);
      cyc(20);
      cmd(1'b1, 1'b0);                              // restart watchdog
      cyc(20);
      chk_bit("wdog restarted", 1'b1, act);
      cyc(20);
      chk_bit("wdog stop", 1'b0, act);
      chk_bit("wdog error", 1'b1, werr);
      chk_bit("fault", 1'b1, fault);
      ev(3);
      cyc(1);
      chk_bit("error cleared", 1'b0, werr);
      chk_bit("fault cleared", 1'b0, fault);
      // zero threshold written while timed balancing runs
      bal_mode = cbc_pkg::MODE_TIMED;
      thr = {14{7'h05}};
      cmd(1'b1, 1'b0);
      cyc(3);
      thr[6:0] = cbc_pkg::THR_ZERO;
      cyc(2);
      chk_vec("zero thr", 14'h3ffe, drive);
      cmd(1'b0, 1'b1);
      // sleep or timeout in each mode and setting, then wake
      thr = {14{cbc_pkg::THR_MAX}};
      for (i = 0; i < 4; i++) begin
         bal_mode = i < 2 ? cbc_pkg::MODE_MANUAL : cbc_pkg::MODE_TIMED;
         conf = (i == 0 || i == 3);
         cmd(1'b1, 1'b0);
         ev(i % 2);
         cyc(1);
         chk_bit("sleep run", i == 3, act);
         chk_bit("silent", i == 3, silent);
         ev(2);
         cyc(1);
         chk_bit("wake run", 1'b0, act);
         chk_bit("wake silent", 1'b0, silent);
         cmd(1'b0, 1'b1);
      end
      // mid-run reset clears state and drive at once
      bal_mode = cbc_pkg::MODE_MANUAL;
      md = 14'h3fff;
      cmd(1'b1, 1'b0);
      resetn = 1'b0;
      cyc(2);
      chk_vec("reset drive", 14'h0000, drive);
      chk_bit("reset run", 1'b0, act);
      resetn = 1'b1;
      cyc(1);
      chk_bit("release run", 1'b0, act);
      chk_bit("release error", 1'b0, werr);
      for (i = 0; i < 3; i++) timed_run(1'b1);
      timed_run(1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
